// [include/sfr_map_pkg.sv]
// Address map, reset values and fixed-bit layout of the special register space.
`default_nettype none
package sfr_map_pkg;

    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 8;
    localparam int          BANK_DEPTH = 128;
    localparam logic [7:0]  SPACE_BASE = 8'h80;

    // Register addresses.
    localparam logic [7:0]  ADR_PORT_ZERO_LATCH              = 8'h80;
    localparam logic [7:0]  ADR_STACK_POINTER                = 8'h81;
    localparam logic [7:0]  ADR_DATA_POINTER_A_LOW           = 8'h82;
    localparam logic [7:0]  ADR_DATA_POINTER_A_HIGH          = 8'h83;
    localparam logic [7:0]  ADR_DATA_POINTER_B_LOW           = 8'h84;
    localparam logic [7:0]  ADR_DATA_POINTER_B_HIGH          = 8'h85;
    localparam logic [7:0]  ADR_POINTER_SELECT               = 8'h86;
    localparam logic [7:0]  ADR_POWER_CONTROL                = 8'h87;
    localparam logic [7:0]  ADR_TIMER_CONTROL                = 8'h88;
    localparam logic [7:0]  ADR_TIMER_MODE                   = 8'h89;
    localparam logic [7:0]  ADR_TIMER0_COUNT_LOW             = 8'h8A;
    localparam logic [7:0]  ADR_TIMER1_COUNT_LOW             = 8'h8B;
    localparam logic [7:0]  ADR_TIMER0_COUNT_HIGH            = 8'h8C;
    localparam logic [7:0]  ADR_TIMER1_COUNT_HIGH            = 8'h8D;
    localparam logic [7:0]  ADR_CLOCK_RATE_CONTROL           = 8'h8E;
    localparam logic [7:0]  ADR_SPECIAL_FUNCTION_SELECT      = 8'h8F;
    localparam logic [7:0]  ADR_PORT_ONE_LATCH               = 8'h90;
    localparam logic [7:0]  ADR_EXTENDED_INTERRUPT_FLAGS     = 8'h91;
    localparam logic [7:0]  ADR_PORT_ZERO_DIRECTION          = 8'h94;
    localparam logic [7:0]  ADR_PORT_ZERO_ALTERNATE          = 8'h95;
    localparam logic [7:0]  ADR_PORT_ONE_DIRECTION           = 8'h96;
    localparam logic [7:0]  ADR_SERIAL_CONTROL               = 8'h98;
    localparam logic [7:0]  ADR_SERIAL_BUFFER                = 8'h99;
    localparam logic [7:0]  ADR_RADIO_PORT_LINES             = 8'hA0;
    localparam logic [7:0]  ADR_INTERRUPT_ENABLE             = 8'hA8;
    localparam logic [7:0]  ADR_PULSE_WIDTH_CONFIG           = 8'hA9;
    localparam logic [7:0]  ADR_PULSE_WIDTH_DUTY             = 8'hAA;
    localparam logic [7:0]  ADR_WDOG_RTC_STAGE_HIGH          = 8'hAB;
    localparam logic [7:0]  ADR_WDOG_RTC_STAGE_LOW           = 8'hAC;
    localparam logic [7:0]  ADR_WDOG_RTC_STAGE_CONTROL       = 8'hAD;
    localparam logic [7:0]  ADR_RESET_CAUSE                  = 8'hB1;
    localparam logic [7:0]  ADR_SERIAL_PERIPH_DATA           = 8'hB2;
    localparam logic [7:0]  ADR_SERIAL_PERIPH_CONTROL        = 8'hB3;
    localparam logic [7:0]  ADR_SERIAL_PERIPH_RATE           = 8'hB4;
    localparam logic [7:0]  ADR_INTERRUPT_PRIORITY           = 8'hB8;
    localparam logic [7:0]  ADR_CRYSTAL_OUTPUT_CONFIG        = 8'hBF;
    localparam logic [7:0]  ADR_TIMER2_CONTROL               = 8'hC8;
    localparam logic [7:0]  ADR_TIMER2_RELOAD_LOW            = 8'hCA;
    localparam logic [7:0]  ADR_TIMER2_RELOAD_HIGH           = 8'hCB;
    localparam logic [7:0]  ADR_TIMER2_COUNT_LOW             = 8'hCC;
    localparam logic [7:0]  ADR_TIMER2_COUNT_HIGH            = 8'hCD;
    localparam logic [7:0]  ADR_PROGRAM_STATUS_WORD          = 8'hD0;
    localparam logic [7:0]  ADR_EXTENDED_INTERRUPT_CONTROL   = 8'hD8;
    localparam logic [7:0]  ADR_ACCUMULATOR                  = 8'hE0;
    localparam logic [7:0]  ADR_EXTENDED_INTERRUPT_ENABLE    = 8'hE8;
    localparam logic [7:0]  ADR_MULTIPLY_DIVIDE_OPERAND      = 8'hF0;
    localparam logic [7:0]  ADR_EXTENDED_INTERRUPT_PRIORITY  = 8'hF8;
    localparam logic [7:0]  ADR_SILICON_REVISION             = 8'hFE;
    localparam logic [7:0]  ADR_RESERVED_TOP                 = 8'hFF;

    // Reset values that differ from zero, then the zero default for all others.
    localparam logic [7:0]  RST_PORT_ZERO_LATCH              = 8'hFF;
    localparam logic [7:0]  RST_STACK_POINTER                = 8'h07;
    localparam logic [7:0]  RST_POWER_CONTROL                = 8'h30;
    localparam logic [7:0]  RST_CLOCK_RATE_CONTROL           = 8'h01;
    localparam logic [7:0]  RST_PORT_ONE_LATCH               = 8'hFF;
    localparam logic [7:0]  RST_EXTENDED_INTERRUPT_FLAGS     = 8'h08;
    localparam logic [7:0]  RST_PORT_ZERO_DIRECTION          = 8'hFF;
    localparam logic [7:0]  RST_PORT_ONE_DIRECTION           = 8'hF4;
    localparam logic [7:0]  RST_RADIO_PORT_LINES             = 8'h08;
    localparam logic [7:0]  RST_RESET_CAUSE                  = 8'h02;
    localparam logic [7:0]  RST_INTERRUPT_PRIORITY           = 8'h80;
    localparam logic [7:0]  RST_CRYSTAL_OUTPUT_CONFIG        = 8'h27;
    localparam logic [7:0]  RST_EXTENDED_INTERRUPT_CONTROL   = 8'h40;
    localparam logic [7:0]  RST_EXTENDED_INTERRUPT_ENABLE    = 8'hE0;
    localparam logic [7:0]  RST_EXTENDED_INTERRUPT_PRIORITY  = 8'hE0;
    localparam logic [7:0]  RST_DEFAULT                      = 8'h00;

    // Hard-wired bits: mask marks the fixed positions, value gives their level.
    localparam logic [7:0]  FIX_MASK_POINTER_SELECT          = 8'hFE;
    localparam logic [7:0]  FIX_VAL_POINTER_SELECT           = 8'h00;
    localparam logic [7:0]  FIX_MASK_POWER_CONTROL           = 8'h30;
    localparam logic [7:0]  FIX_VAL_POWER_CONTROL            = 8'h30;
    localparam logic [7:0]  FIX_MASK_SPECIAL_FUNCTION_SELECT = 8'hFE;
    localparam logic [7:0]  FIX_VAL_SPECIAL_FUNCTION_SELECT  = 8'h00;
    localparam logic [7:0]  FIX_MASK_EXT_INT_FLAGS           = 8'h0F;
    localparam logic [7:0]  FIX_VAL_EXT_INT_FLAGS            = 8'h08;
    localparam logic [7:0]  FIX_MASK_INTERRUPT_ENABLE        = 8'h40;
    localparam logic [7:0]  FIX_VAL_INTERRUPT_ENABLE         = 8'h00;
    localparam logic [7:0]  FIX_MASK_INTERRUPT_PRIORITY      = 8'hC0;
    localparam logic [7:0]  FIX_VAL_INTERRUPT_PRIORITY       = 8'h80;
    localparam logic [7:0]  FIX_MASK_EXT_INT_CONTROL         = 8'h77;
    localparam logic [7:0]  FIX_VAL_EXT_INT_CONTROL          = 8'h40;
    localparam logic [7:0]  FIX_MASK_EXT_INT_ENABLE          = 8'hE0;
    localparam logic [7:0]  FIX_VAL_EXT_INT_ENABLE           = 8'hE0;
    localparam logic [7:0]  FIX_MASK_EXT_INT_PRIORITY        = 8'hE0;
    localparam logic [7:0]  FIX_VAL_EXT_INT_PRIORITY         = 8'hE0;
    localparam logic [7:0]  FIX_NONE                         = 8'h00;

    // Arbitrary neutral revision value; the real part supplies its own.
    localparam logic [7:0]  SILICON_REVISION_DEFAULT         = 8'h00;

    localparam int          POINTER_SELECT_BIT = 0;

endpackage
`default_nettype wire

// [rtl/sfr_read_port.sv]
// Registered read-data stage of the special register bank.
`default_nettype none
module sfr_read_port
    import sfr_map_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              rd_i,
    input  wire logic              hit_i,
    input  wire logic [DATA_W-1:0] data_i,
    output var  logic [DATA_W-1:0] rdata_o,
    output var  logic              rd_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // A miss still answers, with zero, so the core never waits on a hole.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            rdata_o <= hit_i ? data_i : 8'h00;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= rd_i;
        end
    end

endmodule
`default_nettype wire

// [rtl/sfr_space_decode_map.sv]
// Special register bank of the upper direct address space with decode and fixed bits.
`default_nettype none
module sfr_space_decode_map
    import sfr_map_pkg::*;
#(
    parameter logic [7:0] SILICON_REVISION = SILICON_REVISION_DEFAULT
)
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              wdog_rst_i,
    input  wire logic [ADDR_W-1:0] sfr_addr_i,
    input  wire logic              sfr_wr_i,
    input  wire logic              sfr_rd_i,
    input  wire logic [DATA_W-1:0] sfr_wdata_i,
    output var  logic [DATA_W-1:0] sfr_rdata_o,
    output var  logic              sfr_rd_valid_o,
    output var  logic              reserved_wr_o,
    output var  logic              pointer_sel_o,
    output var  logic [7:0]        port_zero_alternate_o,
    output var  logic [15:0]       wdog_rtc_stage_o,
    output var  logic [15:0]       timer2_reload_o,
    output var  logic [15:0]       timer2_count_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode functions.

    // Every assigned register of the upper half; the reserved top address is not one.
    function automatic logic reg_known(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a[7])
        begin
            case (a)
                ADR_PORT_ZERO_LATCH,
                ADR_STACK_POINTER,
                ADR_DATA_POINTER_A_LOW,
                ADR_DATA_POINTER_A_HIGH,
                ADR_DATA_POINTER_B_LOW,
                ADR_DATA_POINTER_B_HIGH,
                ADR_POINTER_SELECT,
                ADR_POWER_CONTROL,
                ADR_TIMER_CONTROL,
                ADR_TIMER_MODE,
                ADR_TIMER0_COUNT_LOW,
                ADR_TIMER1_COUNT_LOW,
                ADR_TIMER0_COUNT_HIGH,
                ADR_TIMER1_COUNT_HIGH,
                ADR_CLOCK_RATE_CONTROL,
                ADR_SPECIAL_FUNCTION_SELECT,
                ADR_PORT_ONE_LATCH,
                ADR_EXTENDED_INTERRUPT_FLAGS,
                ADR_PORT_ZERO_DIRECTION,
                ADR_PORT_ZERO_ALTERNATE,
                ADR_PORT_ONE_DIRECTION,
                ADR_SERIAL_CONTROL,
                ADR_SERIAL_BUFFER,
                ADR_RADIO_PORT_LINES,
                ADR_INTERRUPT_ENABLE,
                ADR_PULSE_WIDTH_CONFIG,
                ADR_PULSE_WIDTH_DUTY,
                ADR_WDOG_RTC_STAGE_HIGH,
                ADR_WDOG_RTC_STAGE_LOW,
                ADR_WDOG_RTC_STAGE_CONTROL,
                ADR_RESET_CAUSE,
                ADR_SERIAL_PERIPH_DATA,
                ADR_SERIAL_PERIPH_CONTROL,
                ADR_SERIAL_PERIPH_RATE,
                ADR_INTERRUPT_PRIORITY,
                ADR_CRYSTAL_OUTPUT_CONFIG,
                ADR_TIMER2_CONTROL,
                ADR_TIMER2_RELOAD_LOW,
                ADR_TIMER2_RELOAD_HIGH,
                ADR_TIMER2_COUNT_LOW,
                ADR_TIMER2_COUNT_HIGH,
                ADR_PROGRAM_STATUS_WORD,
                ADR_EXTENDED_INTERRUPT_CONTROL,
                ADR_ACCUMULATOR,
                ADR_EXTENDED_INTERRUPT_ENABLE,
                ADR_MULTIPLY_DIVIDE_OPERAND,
                ADR_EXTENDED_INTERRUPT_PRIORITY,
                ADR_SILICON_REVISION:
                    hit = 1'b1;
                default:
                    hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    function automatic logic reg_read_only(input logic [7:0] a);
        return a == ADR_SILICON_REVISION;
    endfunction

    function automatic logic [7:0] reg_fix_mask(input logic [7:0] a);
        logic [7:0] m;
        case (a)
            ADR_POINTER_SELECT:              m = FIX_MASK_POINTER_SELECT;
            ADR_POWER_CONTROL:               m = FIX_MASK_POWER_CONTROL;
            ADR_SPECIAL_FUNCTION_SELECT:     m = FIX_MASK_SPECIAL_FUNCTION_SELECT;
            ADR_EXTENDED_INTERRUPT_FLAGS:    m = FIX_MASK_EXT_INT_FLAGS;
            ADR_INTERRUPT_ENABLE:            m = FIX_MASK_INTERRUPT_ENABLE;
            ADR_INTERRUPT_PRIORITY:          m = FIX_MASK_INTERRUPT_PRIORITY;
            ADR_EXTENDED_INTERRUPT_CONTROL:  m = FIX_MASK_EXT_INT_CONTROL;
            ADR_EXTENDED_INTERRUPT_ENABLE:   m = FIX_MASK_EXT_INT_ENABLE;
            ADR_EXTENDED_INTERRUPT_PRIORITY: m = FIX_MASK_EXT_INT_PRIORITY;
            default:                         m = FIX_NONE;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] reg_fix_val(input logic [7:0] a);
        logic [7:0] v;
        case (a)
            ADR_POINTER_SELECT:              v = FIX_VAL_POINTER_SELECT;
            ADR_POWER_CONTROL:               v = FIX_VAL_POWER_CONTROL;
            ADR_SPECIAL_FUNCTION_SELECT:     v = FIX_VAL_SPECIAL_FUNCTION_SELECT;
            ADR_EXTENDED_INTERRUPT_FLAGS:    v = FIX_VAL_EXT_INT_FLAGS;
            ADR_INTERRUPT_ENABLE:            v = FIX_VAL_INTERRUPT_ENABLE;
            ADR_INTERRUPT_PRIORITY:          v = FIX_VAL_INTERRUPT_PRIORITY;
            ADR_EXTENDED_INTERRUPT_CONTROL:  v = FIX_VAL_EXT_INT_CONTROL;
            ADR_EXTENDED_INTERRUPT_ENABLE:   v = FIX_VAL_EXT_INT_ENABLE;
            ADR_EXTENDED_INTERRUPT_PRIORITY: v = FIX_VAL_EXT_INT_PRIORITY;
            default:                         v = FIX_NONE;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] reg_reset_val(input logic [7:0] a);
        logic [7:0] r;
        case (a)
            ADR_PORT_ZERO_LATCH:             r = RST_PORT_ZERO_LATCH;
            ADR_STACK_POINTER:               r = RST_STACK_POINTER;
            ADR_POWER_CONTROL:               r = RST_POWER_CONTROL;
            ADR_CLOCK_RATE_CONTROL:          r = RST_CLOCK_RATE_CONTROL;
            ADR_PORT_ONE_LATCH:              r = RST_PORT_ONE_LATCH;
            ADR_EXTENDED_INTERRUPT_FLAGS:    r = RST_EXTENDED_INTERRUPT_FLAGS;
            ADR_PORT_ZERO_DIRECTION:         r = RST_PORT_ZERO_DIRECTION;
            ADR_PORT_ONE_DIRECTION:          r = RST_PORT_ONE_DIRECTION;
            ADR_RADIO_PORT_LINES:            r = RST_RADIO_PORT_LINES;
            ADR_RESET_CAUSE:                 r = RST_RESET_CAUSE;
            ADR_INTERRUPT_PRIORITY:          r = RST_INTERRUPT_PRIORITY;
            ADR_CRYSTAL_OUTPUT_CONFIG:       r = RST_CRYSTAL_OUTPUT_CONFIG;
            ADR_EXTENDED_INTERRUPT_CONTROL:  r = RST_EXTENDED_INTERRUPT_CONTROL;
            ADR_EXTENDED_INTERRUPT_ENABLE:   r = RST_EXTENDED_INTERRUPT_ENABLE;
            ADR_EXTENDED_INTERRUPT_PRIORITY: r = RST_EXTENDED_INTERRUPT_PRIORITY;
            default:                         r = RST_DEFAULT;
        endcase
        return r;
    endfunction

    function automatic logic [6:0] bank_index(input logic [7:0] a);
        return a[6:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage. Unused bit positions are kept like any other bit and only read back.

    logic [7:0] bank_reg [0:BANK_DEPTH-1];
    logic       addr_known;
    logic       wr_accept;
    logic [7:0] wr_value;
    logic [7:0] rd_value;

    assign addr_known = reg_known(sfr_addr_i);
    assign wr_accept  = sfr_wr_i && addr_known && !reg_read_only(sfr_addr_i);

    // Fixed positions are forced on the way in so storage never holds a wrong constant.
    assign wr_value = (sfr_wdata_i & ~reg_fix_mask(sfr_addr_i))
                    | reg_fix_val(sfr_addr_i);

    // The bank is plain storage: classic registers behave as the core expects them.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < BANK_DEPTH; i++)
            begin
                bank_reg[i] <= reg_reset_val(SPACE_BASE | 8'(i));
            end
        end
        else if (wdog_rst_i)
        begin
            for (int i = 0; i < BANK_DEPTH; i++)
            begin
                bank_reg[i] <= reg_reset_val(SPACE_BASE | 8'(i));
            end
        end
        else if (wr_accept)
        begin
            bank_reg[bank_index(sfr_addr_i)] <= wr_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path. Constants are laid over stored data once more so reads stay exact.

    always_comb
    begin
        rd_value = 8'h00;
        if (reg_read_only(sfr_addr_i))
        begin
            rd_value = SILICON_REVISION;
        end
        else if (addr_known)
        begin
            rd_value = (bank_reg[bank_index(sfr_addr_i)] & ~reg_fix_mask(sfr_addr_i))
                     | reg_fix_val(sfr_addr_i);
        end
    end

    sfr_read_port u_read_port (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .rd_i       (sfr_rd_i),
        .hit_i      (addr_known),
        .data_i     (rd_value),
        .rdata_o    (sfr_rdata_o),
        .rd_valid_o (sfr_rd_valid_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // A write to an unassigned or read-only address is flagged for one cycle so a debugger can catch stray code.

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reserved_wr_o <= 1'b0;
        end
        else
        begin
            reserved_wr_o <= sfr_wr_i && !wr_accept;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register fields that steer logic outside the bank.

    assign pointer_sel_o =
        bank_reg[bank_index(ADR_POINTER_SELECT)][POINTER_SELECT_BIT];

    assign port_zero_alternate_o = bank_reg[bank_index(ADR_PORT_ZERO_ALTERNATE)];

    assign wdog_rtc_stage_o = {bank_reg[bank_index(ADR_WDOG_RTC_STAGE_HIGH)],
                               bank_reg[bank_index(ADR_WDOG_RTC_STAGE_LOW)]};

    assign timer2_reload_o = {bank_reg[bank_index(ADR_TIMER2_RELOAD_HIGH)],
                              bank_reg[bank_index(ADR_TIMER2_RELOAD_LOW)]};

    assign timer2_count_o = {bank_reg[bank_index(ADR_TIMER2_COUNT_HIGH)],
                             bank_reg[bank_index(ADR_TIMER2_COUNT_LOW)]};

endmodule
`default_nettype wire

// [tb/sfr_space_decode_map_properties.sv]
// Port-level checks for the special register bank.
`default_nettype none
module sfr_space_decode_map_chk
    import sfr_map_pkg::*;
#(
    parameter logic [7:0] SILICON_REVISION = 8'h00
)
(
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    input wire logic              wdog_rst_i,
    input wire logic [ADDR_W-1:0] sfr_addr_i,
    input wire logic              sfr_wr_i,
    input wire logic              sfr_rd_i,
    input wire logic [DATA_W-1:0] sfr_wdata_i,
    input wire logic [DATA_W-1:0] sfr_rdata_o,
    input wire logic              sfr_rd_valid_o,
    input wire logic              reserved_wr_o,
    input wire logic [7:0]        port_zero_alternate_o,
    input wire logic [15:0]       timer2_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    chk_read_answer: assert property
        (sfr_rd_i |=> sfr_rd_valid_o) else $error("Read got no answer.");
    chk_valid_cause: assert property
        (sfr_rd_valid_o |-> $past(sfr_rd_i)) else $error("Answer without read.");
    chk_rdata_holds: assert property
        (!sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("Read data moved.");
    chk_select_fixed: assert property
        (sfr_rd_i && sfr_addr_i == ADR_POINTER_SELECT |=> sfr_rdata_o[7:1] == 7'h00)
        else $error("Select upper bits set.");
    chk_power_fixed: assert property
        (sfr_rd_i && sfr_addr_i == ADR_POWER_CONTROL |=> sfr_rdata_o[5:4] == 2'h3)
        else $error("Power fixed bits wrong.");
    chk_top_zero: assert property
        (sfr_rd_i && sfr_addr_i == ADR_RESERVED_TOP |=> sfr_rdata_o == 8'h00)
        else $error("Top address not zero.");
    chk_revision_read: assert property
        (sfr_rd_i && sfr_addr_i == ADR_SILICON_REVISION |=> sfr_rdata_o == SILICON_REVISION)
        else $error("Revision wrong.");
    chk_reserved_flag: assert property
        (sfr_wr_i && sfr_addr_i inside {8'hFE, 8'hFF} |=> reserved_wr_o)
        else $error("Dropped write not flagged.");
    chk_alt_update: assert property
        (sfr_wr_i && !wdog_rst_i && sfr_addr_i == ADR_PORT_ZERO_ALTERNATE
        |=> port_zero_alternate_o == $past(sfr_wdata_i)) else $error("Alternate not written.");
    chk_wdog_reload: assert property
        (wdog_rst_i |=> port_zero_alternate_o == 8'h00 && timer2_count_o == 16'h0000)
        else $error("Watchdog reload missed.");
endmodule
bind sfr_space_decode_map sfr_space_decode_map_chk #(.SILICON_REVISION(SILICON_REVISION)) u_chk
(
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wdog_rst_i(wdog_rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_rd_valid_o(sfr_rd_valid_o),
    .reserved_wr_o(reserved_wr_o), .port_zero_alternate_o(port_zero_alternate_o),
    .timer2_count_o(timer2_count_o)
);
`default_nettype wire

// [tb/core_bus_model.sv]
// Behavioural processor core driving the special register bus.
`default_nettype none
module core_bus_model
    import sfr_map_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic [DATA_W-1:0] sfr_rdata_i,
    input  wire logic              sfr_rd_valid_i,
    input  wire logic              reserved_wr_i,
    output var  logic [ADDR_W-1:0] sfr_addr_o,
    output var  logic              sfr_wr_o,
    output var  logic              sfr_rd_o,
    output var  logic [DATA_W-1:0] sfr_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sfr_addr_o = 8'h00;
        sfr_wr_o = 1'b0;
        sfr_rd_o = 1'b0;
        sfr_wdata_o = 8'h00;
    end
    // Reserved places are written only when the caller asks for it on purpose.
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d, output logic f);
        @(negedge clk_sys_i);
        sfr_addr_o = a;
        sfr_wdata_o = d;
        sfr_wr_o = 1'b1;
        @(negedge clk_sys_i);
        sfr_wr_o = 1'b0;
        // Stale data is inverted so nothing can lean on a leftover value.
        sfr_wdata_o = ~d;
        f = reserved_wr_i;
    endtask
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys_i);
        sfr_addr_o = a;
        sfr_rd_o = 1'b1;
        @(negedge clk_sys_i);
        sfr_rd_o = 1'b0;
        d = sfr_rdata_i;
        v = sfr_rd_valid_i;
    endtask
endmodule
`default_nettype wire

// [tb/tb_sfr_space_decode_map.sv]
// Self-checking bench for the special register bank.
`default_nettype none
module tb_sfr_space_decode_map
    import sfr_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REV = 8'h5C; // Arbitrary revision value.
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        wdog_rst_i = 1'b0;
    logic [7:0]  addr, wdata, rdata, alt;
    logic        wr, rd, rd_valid, reserved_wr, pointer_sel;
    logic [15:0] stage, reload, count;
    logic [7:0]  ev [256];
    int          fail_count = 0;
    int          check_count = 0;
    int          seed = 94528;
    always #4 clk_sys_i = ~clk_sys_i;
    sfr_space_decode_map #(.SILICON_REVISION(REV)) uut (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .wdog_rst_i(wdog_rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_rd_valid_o(rd_valid),
        .reserved_wr_o(reserved_wr), .pointer_sel_o(pointer_sel), .port_zero_alternate_o(alt),
        .wdog_rtc_stage_o(stage), .timer2_reload_o(reload), .timer2_count_o(count));
    core_bus_model core (.clk_sys_i(clk_sys_i), .sfr_rdata_i(rdata), .sfr_rd_valid_i(rd_valid),
        .reserved_wr_i(reserved_wr), .sfr_addr_o(addr), .sfr_wr_o(wr), .sfr_rd_o(rd),
        .sfr_wdata_o(wdata));
    function automatic logic mapped(input logic [7:0] a);
        return a inside {[8'h80:8'h91], [8'h94:8'h96], 8'h98, 8'h99, 8'hA0, [8'hA8:8'hAD],
            [8'hB1:8'hB4], 8'hB8, 8'hBF, 8'hC8, [8'hCA:8'hCD], 8'hD0, 8'hD8, 8'hE0, 8'hE8,
            8'hF0, 8'hF8};
    endfunction
    // Upper byte masks the hard-wired bits, lower byte gives their level.
    function automatic logic [15:0] fixed_bits(input logic [7:0] a);
        case (a)
            8'h86, 8'h8F: return 16'hFE00;
            8'h87: return 16'h3030;
            8'h91: return 16'h0F08;
            8'hA8: return 16'h4000;
            8'hB8: return 16'hC080;
            8'hD8: return 16'h7740;
            8'hE8, 8'hF8: return 16'hE0E0;
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [7:0] reset_val(input logic [7:0] a);
        case (a)
            8'h80, 8'h90, 8'h94: return 8'hFF;
            8'h81: return 8'h07;
            8'h87: return 8'h30;
            8'h8E: return 8'h01;
            8'h91, 8'hA0: return 8'h08;
            8'h96: return 8'hF4;
            8'hB1: return 8'h02;
            8'hB8: return 8'h80;
            8'hBF: return 8'h27;
            8'hD8: return 8'h40;
            8'hE8, 8'hF8: return 8'hE0;
            8'hFE: return REV;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] stored(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] f;
        f = fixed_bits(a);
        if (a == 8'hFE) return REV;
        if (!mapped(a)) return 8'h00;
        return (d & ~f[15:8]) | (f[7:0] & f[15:8]);
    endfunction
    task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Addresses below the space are swept too; they must act as unassigned.
    task automatic sweep_reset();
        logic [7:0] d;
        logic       v;
        for (int a = 8'h78; a < 256; a++)
        begin
            core.read_byte(8'(a), d, v);
            check_flag(v, 1'b1);
            check_value(16'(d), 16'(reset_val(8'(a))));
        end
    endtask
    initial
    begin
        logic [7:0] d, r;
        logic       f, v;
        repeat (3) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        sweep_reset();
        // All-zero and all-one passes hit the fixed bits hardest; the last pass is random.
        for (int p = 0; p < 3; p++)
        begin
            for (int a = 8'h78; a < 256; a++)
            begin
                d = (p == 0) ? 8'h00 : (p == 1) ? 8'hFF : 8'($random(seed));
                core.write_byte(8'(a), d, f);
                ev[a] = stored(8'(a), d);
                check_flag(f, !mapped(8'(a)));
                core.read_byte(8'(a), r, v);
                check_value(16'(r), 16'(ev[a]));
            end
        end
        check_value(16'(alt), 16'(ev[8'h95]));
        check_flag(pointer_sel, ev[8'h86][0]);
        check_value(stage, {ev[8'hAB], ev[8'hAC]});
        check_value(reload, {ev[8'hCB], ev[8'hCA]});
        check_value(count, {ev[8'hCD], ev[8'hCC]});
        // A write in the reload cycle must lose, so one is issued alongside it.
        fork
            core.write_byte(8'h95, 8'h5A, f);
            begin
                @(negedge clk_sys_i);
                wdog_rst_i = 1'b1;
                @(negedge clk_sys_i);
                wdog_rst_i = 1'b0;
            end
        join
        check_flag(f, 1'b0);
        sweep_reset();
        check_value({alt, 7'h00, pointer_sel}, 16'h0000);
        check_value(stage | reload | count, 16'h0000);
        wrap_up();
    end
    initial
    begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
